// [led_port_cfg.svh]
// Constants of the serial word port: field positions, offsets, reset values, timing.
// Assumes a single 10 MHz core clock; included by bare name.
// How it works
// - Data word fields: address, intensities, watchdog, divisor, brightness.
// - Data bit 24 high disables the watchdog.
// - Status word: open flags, watchdog, thermal, revision, filler.
// - Bank A status bit zero means open.
// - Bank B status bit zero means open.
// - Status bit 17 is one after timeout.
// - Status bit 18 is one when overheated.
// - Status bits 22-36 alternate, zero at both ends.
// - Timeout after 25-200 us without clock edges.
// - Load low shifts; load high, first fall transfers.
// - Next rise with load high captures status.
// - Bit 36 enters first and leaves first.
// - Output off while PWM count exceeds intensity.
`ifndef LED_PORT_CFG_SVH
`define LED_PORT_CFG_SVH
// Data word field positions (word bit n sits at index n-1)
`define F_ADDR_LSB 0
`define F_INT_A_LSB 3
`define F_INT_B_LSB 13
`define F_WD_DIS 23
`define F_DIV_LSB 24
`define F_DAC_A_LSB 28
`define F_DAC_B_LSB 32
// Status word field positions
`define S_OPEN_A_LSB 0
`define S_OPEN_B_LSB 8
`define S_WD 16
`define S_THERM 17
`define S_REV_LSB 18
`define S_FILL_LSB 21
`define S_FILLER 15'h2AAA
// Register offsets (bytes)
`define REG_IRQ_STAT 8'h00
`define REG_IRQ_MASK 8'h04
`define REG_CONFIG 8'h08
`define REG_STATUS 8'h0C
// Reset values
`define IRQ_MASK_RST 4'h0
`define DIV_RST 4'h0
`define DAC_RST 4'h0
// Interrupt bit positions
`define IRQ_LOADED 0
`define IRQ_WDOG 1
`define IRQ_THERM 2
`define IRQ_OPEN 3
// Timing: core period and watchdog window, in ns
`define CLK_PERIOD_NS 100
`define WD_MIN_NS 25000
`define WD_MAX_NS 200000
// Longest time rounds down to whole cycles
`define WD_TIMEOUT_CYC ((`WD_MAX_NS) / (`CLK_PERIOD_NS))
`endif

// [led_port_pkg.sv]
// Types shared by the serial word port, its controller model and its bench.
// Assumes the constants header is included alongside.
package led_port_pkg;
  // Load sequence of the serial port
  typedef enum logic [1:0] {
    LS_SHIFT = 2'b00,
    LS_XFER = 2'b01,
    LS_CAPT = 2'b10,
    LS_HOLD = 2'b11
  } ld_state_type;
  typedef logic [35:0] word_type;
  typedef logic [3:0] dac_type;
  typedef logic [9:0] level_type;
endpackage

// [intensity_mem_if.sv]
// Port bundle between the serial port core and its intensity store.
// Assumes both sides run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface intensity_mem_if #(parameter int AW = 4, parameter int DW = 10);
  logic wr_en; // One-cycle write strobe
  logic [AW-1:0] wr_addr; // Channel written
  logic [DW-1:0] wr_data; // Intensity written
  logic [AW-1:0] rd_addr; // Channel read
  logic [DW-1:0] rd_data; // Registered read data
  modport core (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport store (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface
`default_nettype wire

// [intensity_mem.sv]
// Intensity store: one word per output channel, registered read.
// Assumes one write port and one read port on the core clock.
`timescale 1ns/1ps
`default_nettype none
module intensity_mem #(
  parameter int AW = 4,
  parameter int DW = 10
) (
  input wire logic ref_clk_i,
  intensity_mem_if.store mem
);
  // No reset: the core keeps outputs off until the first load
  logic [DW-1:0] ram_r [0:(1<<AW)-1];
  logic [DW-1:0] rd_r;
  // Write and registered read
  always_ff @(posedge ref_clk_i) begin
    if (mem.wr_en) begin
      ram_r[mem.wr_addr] <= mem.wr_data;
    end
    rd_r <= ram_r[mem.rd_addr];
  end
  assign mem.rd_data = rd_r;
endmodule
`default_nettype wire

// [led_serial_port.sv]
// Serial control/status word port of a dual-bank 16-output LED sink driver.
// Assumes the serial clock is well below a quarter of the 10 MHz core clock.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "led_port_cfg.svh"
module led_serial_port #(
  parameter logic [2:0] MASK_REV = 3'h1, // Arbitrary revision value
  parameter int WD_CYC = `WD_TIMEOUT_CYC
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic serial_bit_clock_i,
  input wire logic serial_data_in_i,
  input wire logic load_i,
  input wire logic thermal_trip_i,
  input wire logic [7:0] open_a_i,
  input wire logic [7:0] open_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic serial_data_out_o,
  output logic [7:0] led_a_o,
  output logic [7:0] led_b_o,
  output var led_port_pkg::dac_type dac_a_o,
  output var led_port_pkg::dac_type dac_b_o,
  output logic irq_o
);
  import led_port_pkg::*;

  localparam int PW = 20; // Pins that cross into the core clock
  logic [PW-1:0] meta_r, sync_r; // Two-flop synchroniser
  logic sclk_d_r; // Delayed synced clock for edges
  logic sclk_s, din_s, load_s, therm_s;
  logic [7:0] open_a_s, open_b_s;
  logic rise, fall;

  // Pin synchroniser; first stage feeds only the second
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      sync_r <= '0;
      sclk_d_r <= 1'b0;
    end else begin
      meta_r <= {serial_bit_clock_i, serial_data_in_i, load_i, thermal_trip_i, open_a_i, open_b_i};
      sync_r <= meta_r;
      sclk_d_r <= sync_r[19];
    end
  end
  assign {sclk_s, din_s, load_s, therm_s, open_a_s, open_b_s} = sync_r;
  assign rise = sclk_s & ~sclk_d_r;
  assign fall = ~sclk_s & sclk_d_r;

  intensity_mem_if #(.AW(4), .DW(10)) mem ();
  intensity_mem #(.AW(4), .DW(10)) u_mem (.ref_clk_i(ref_clk_i), .mem(mem));
  // Core state and next values
  ld_state_type st_r, st_nxt; // Load sequence
  word_type sr_r, sr_nxt; // 36-bit shift register
  word_type status_w; // Live status word
  logic sdo_r, sdo_nxt;
  logic wd_dis_r, wd_dis_nxt; // Watchdog disable
  logic [3:0] div_r, div_nxt; // PWM divisor code
  dac_type dac_a_r, dac_a_nxt, dac_b_r, dac_b_nxt;
  logic loaded_r, loaded_nxt; // Outputs stay off until first word
  logic pend_r, pend_nxt; // Bank B write still due
  logic [2:0] paddr_r, paddr_nxt;
  level_type pdata_r, pdata_nxt;
  logic [11:0] wd_cnt_r, wd_cnt_nxt; // Cycles since last clock edge
  logic wd_flag_r, wd_flag_nxt;
  logic [3:0] pre_r, pre_nxt; // PWM prescaler
  level_type pwm_cnt_r, pwm_cnt_nxt; // Free-running PWM count
  logic [3:0] scan_r, scan_nxt, scan_d_r, scan_d_nxt; // Channel scan
  logic [7:0] led_a_r, led_a_nxt, led_b_r, led_b_nxt;
  logic therm_d_r, therm_d_nxt;
  logic [15:0] open_d_r, open_d_nxt;
  logic [3:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
  logic irq_r, irq_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic kill, ch_on, xfer, capt;
  localparam logic [11:0] WD_LIM = 12'(WD_CYC);
  // Open output reads zero; filler and revision are fixed
  always_comb begin
    status_w = '0;
    status_w[`S_OPEN_A_LSB +: 8] = ~open_a_s;
    status_w[`S_OPEN_B_LSB +: 8] = ~open_b_s;
    status_w[`S_WD] = wd_flag_r;
    status_w[`S_THERM] = therm_s;
    status_w[`S_REV_LSB +: 3] = MASK_REV;
    status_w[`S_FILL_LSB +: 15] = `S_FILLER;
  end
  // Fault, watchdog and power-on hold all outputs off
  assign kill = wd_flag_r | therm_s | ~loaded_r;
  // Output sinks while the count has not passed its level
  assign ch_on = ~kill && (pwm_cnt_r <= mem.rd_data);
  // Next values of the load sequence, shift register, configuration and intensity writes
  always_comb begin
    st_nxt = st_r;
    sr_nxt = sr_r;
    wd_dis_nxt = wd_dis_r;
    div_nxt = div_r;
    dac_a_nxt = dac_a_r;
    dac_b_nxt = dac_b_r;
    loaded_nxt = loaded_r;
    pend_nxt = 1'b0;
    paddr_nxt = paddr_r;
    pdata_nxt = pdata_r;
    mem.wr_en = 1'b0;
    mem.wr_addr = '0;
    mem.wr_data = '0;
    xfer = 1'b0;
    capt = 1'b0;
    // Bank B intensity lands one cycle after bank A
    if (pend_r) begin
      mem.wr_en = 1'b1;
      mem.wr_addr = {1'b1, paddr_r};
      mem.wr_data = pdata_r;
    end
    if (!load_s) begin
      // Shift: new bit enters at the bottom, bit 36 leaves first
      st_nxt = LS_SHIFT;
      if (rise) begin
        sr_nxt = {sr_r[34:0], din_s};
      end
    end else begin
      case (st_r)
        LS_SHIFT: begin
          st_nxt = LS_XFER;
        end
        LS_XFER: begin
          // First falling edge copies the word out
          if (fall) begin
            xfer = 1'b1;
            st_nxt = LS_CAPT;
          end
        end
        LS_CAPT: begin
          // Next rising edge loads the status word
          if (rise) begin
            capt = 1'b1;
            sr_nxt = status_w;
            st_nxt = LS_HOLD;
          end
        end
        default: begin
          st_nxt = LS_HOLD;
        end
      endcase
    end
    if (xfer) begin
      // Field LSB is the lowest numbered word bit
      mem.wr_en = 1'b1;
      mem.wr_addr = {1'b0, sr_r[`F_ADDR_LSB +: 3]};
      mem.wr_data = sr_r[`F_INT_A_LSB +: 10];
      pend_nxt = 1'b1;
      paddr_nxt = sr_r[`F_ADDR_LSB +: 3];
      pdata_nxt = sr_r[`F_INT_B_LSB +: 10];
      wd_dis_nxt = sr_r[`F_WD_DIS];
      div_nxt = sr_r[`F_DIV_LSB +: 4];
      dac_a_nxt = sr_r[`F_DAC_A_LSB +: 4];
      dac_b_nxt = sr_r[`F_DAC_B_LSB +: 4];
      loaded_nxt = 1'b1;
    end
    sdo_nxt = sr_nxt[35];
    mem.rd_addr = scan_r;
  end
  // Watchdog, PWM timebase and output scan
  always_comb begin
    // Any edge restarts the quiet-time count, which saturates
    if (rise || fall) begin
      wd_cnt_nxt = '0;
    end else if (wd_cnt_r != WD_LIM) begin
      wd_cnt_nxt = wd_cnt_r + 12'h001;
    end else begin
      wd_cnt_nxt = wd_cnt_r;
    end
    // Flag reads once in the status word, then clears; set wins
    wd_flag_nxt = capt ? 1'b0 : wd_flag_r;
    if (wd_cnt_r == WD_LIM && !wd_dis_r) begin
      wd_flag_nxt = 1'b1;
    end
    // Prescaler divides rising edges by code plus one
    pre_nxt = pre_r;
    pwm_cnt_nxt = pwm_cnt_r;
    if (rise) begin
      if (pre_r >= div_r) begin
        pre_nxt = '0;
        pwm_cnt_nxt = pwm_cnt_r + 10'h001;
      end else begin
        pre_nxt = pre_r + 4'h1;
      end
    end
    // One channel refreshed per cycle staggers output switching
    scan_nxt = scan_r + 4'h1;
    scan_d_nxt = scan_r;
    led_a_nxt = led_a_r;
    led_b_nxt = led_b_r;
    if (kill) begin
      led_a_nxt = '0;
      led_b_nxt = '0;
    end else if (scan_d_r[3]) begin
      led_b_nxt[scan_d_r[2:0]] = ch_on;
    end else begin
      led_a_nxt[scan_d_r[2:0]] = ch_on;
    end
  end
  // Interrupts and register port
  always_comb begin
    therm_d_nxt = therm_s;
    open_d_nxt = {open_b_s, open_a_s};
    ev = '0;
    ev[`IRQ_LOADED] = xfer;
    ev[`IRQ_WDOG] = wd_flag_nxt & ~wd_flag_r;
    ev[`IRQ_THERM] = therm_s & ~therm_d_r;
    ev[`IRQ_OPEN] = |({open_b_s, open_a_s} & ~open_d_r);
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    if (reg_wr_i) begin
      if (reg_addr_i == `REG_IRQ_STAT) begin
        stat_nxt = stat_r & ~reg_wdata_i[3:0];
      end else if (reg_addr_i == `REG_IRQ_MASK) begin
        mask_nxt = reg_wdata_i[3:0];
      end
    end
    // Event in the clearing cycle is kept
    stat_nxt = stat_nxt | ev;
    irq_nxt = |(stat_nxt & mask_nxt);
    rdata_nxt = '0;
    if (reg_rd_i) begin
      if (reg_addr_i == `REG_IRQ_STAT) begin
        rdata_nxt = {28'h0000000, stat_r};
      end else if (reg_addr_i == `REG_IRQ_MASK) begin
        rdata_nxt = {28'h0000000, mask_r};
      end else if (reg_addr_i == `REG_CONFIG) begin
        rdata_nxt = {18'h00000, loaded_r, wd_dis_r, dac_b_r, dac_a_r, div_r};
      end else if (reg_addr_i == `REG_STATUS) begin
        rdata_nxt = {11'h000, status_w[20:0]};
      end
    end
  end
  // Register every group
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= LS_SHIFT;
      sr_r <= '0;
      sdo_r <= 1'b0;
      wd_dis_r <= 1'b0;
      div_r <= `DIV_RST;
      dac_a_r <= `DAC_RST;
      dac_b_r <= `DAC_RST;
      loaded_r <= 1'b0;
      pend_r <= 1'b0;
      paddr_r <= '0;
      pdata_r <= '0;
      wd_cnt_r <= '0;
      wd_flag_r <= 1'b0;
      pre_r <= '0;
      pwm_cnt_r <= '0;
      scan_r <= '0;
      scan_d_r <= '0;
      led_a_r <= '0;
      led_b_r <= '0;
      therm_d_r <= 1'b0;
      open_d_r <= '0;
      stat_r <= '0;
      mask_r <= `IRQ_MASK_RST;
      irq_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      st_r <= st_nxt;
      sr_r <= sr_nxt;
      sdo_r <= sdo_nxt;
      wd_dis_r <= wd_dis_nxt;
      div_r <= div_nxt;
      dac_a_r <= dac_a_nxt;
      dac_b_r <= dac_b_nxt;
      loaded_r <= loaded_nxt;
      pend_r <= pend_nxt;
      paddr_r <= paddr_nxt;
      pdata_r <= pdata_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      wd_flag_r <= wd_flag_nxt;
      pre_r <= pre_nxt;
      pwm_cnt_r <= pwm_cnt_nxt;
      scan_r <= scan_nxt;
      scan_d_r <= scan_d_nxt;
      led_a_r <= led_a_nxt;
      led_b_r <= led_b_nxt;
      therm_d_r <= therm_d_nxt;
      open_d_r <= open_d_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata_o = rdata_r;
  assign serial_data_out_o = sdo_r;
  assign led_a_o = led_a_r;
  assign led_b_o = led_b_r;
  assign dac_a_o = dac_a_r;
  assign dac_b_o = dac_b_r;
  assign irq_o = irq_r;
  // Checks on the design's own behaviour
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_xfer;
    st_r == LS_XFER && load_s && fall;
  endsequence
  sequence s_capt;
    st_r == LS_CAPT && load_s && rise;
  endsequence
  chk_xfer_fields: assert property (s_xfer |=> div_r == $past(sr_r[27:24]) && dac_b_r == $past(sr_r[35:32]))
    else $error("config fields not taken from the word");
  chk_wd_disable: assert property ($rose(wd_flag_r) |-> !$past(wd_dis_r))
    else $error("watchdog fired while disabled");
  chk_status_load: assert property (s_capt |=> sr_r == $past(status_w))
    else $error("status word not captured");
  chk_open_bits: assert property (s_capt |=> sr_r[15:0] == ~$past({open_b_s, open_a_s}))
    else $error("open flag polarity wrong");
  chk_filler_rev: assert property (s_capt |=> sr_r[35:18] == {`S_FILLER, MASK_REV})
    else $error("filler or revision wrong");
  chk_shift_step: assert property (!load_s && rise |=> sr_r == {$past(sr_r[34:0]), $past(din_s)})
    else $error("shift step wrong");
  chk_wd_trip: assert property (wd_cnt_r == WD_LIM && !wd_dis_r |=> wd_flag_r ##1 led_a_o == 8'h00)
    else $error("watchdog timeout not acted on");
  chk_therm_off: assert property (therm_s |=> led_a_o == 8'h00 && led_b_o == 8'h00)
    else $error("outputs on while overheated");
  chk_pwm_step: assert property (rise && pre_r >= div_r |=> pwm_cnt_r == $past(pwm_cnt_r) + 10'h001)
    else $error("pwm count did not advance");
  chk_pwm_off: assert property (!kill && pwm_cnt_r > mem.rd_data |=>
    ($past(scan_d_r[3]) ? !led_b_o[$past(scan_d_r[2:0])] : !led_a_o[$past(scan_d_r[2:0])]))
    else $error("output on past its level");
  chk_irq_level: assert property (|(stat_r & mask_r) |-> irq_o)
    else $error("interrupt low with unmasked status");
endmodule
`default_nettype wire

// [ctrl_model.sv]
// Display controller model: drives the serial clock, data and load pins of one device.
// Assumes the core clock of the bench; each serial clock phase of a data bit lasts five core cycles.
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  input wire logic ref_clk_i,
  input wire logic serial_data_out_i,
  output logic serial_bit_clock_o,
  output logic serial_data_in_o,
  output logic load_o
);
  import led_port_pkg::*;
  // Idle state: clock stands still low, load low
  initial begin
    serial_bit_clock_o = 1'b0;
    serial_data_in_o = 1'b0;
    load_o = 1'b0;
  end
  // Wait a number of core clock edges
  task automatic gap(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // One frame: 36 bits with bit 36 first, then the load sequence
  // Status is read before each rise, so the old word leaves as the new one enters
  task automatic frame(input word_type w, output word_type st);
    for (int i = 35; i >= 0; i--) begin
      serial_bit_clock_o <= 1'b0;
      serial_data_in_o <= w[i];
      gap(5);
      st[i] = serial_data_out_i;
      serial_bit_clock_o <= 1'b1;
      gap(5);
    end
    load_o <= 1'b1;
    gap(5);
    serial_bit_clock_o <= 1'b0; // Fall transfers the word
    gap(5);
    serial_bit_clock_o <= 1'b1; // Rise captures status
    gap(5);
    load_o <= 1'b0;
    gap(5);
    serial_bit_clock_o <= 1'b0;
    // Released data line shows the inverse so a stale bit never looks valid
    serial_data_in_o <= ~serial_data_in_o;
  endtask
endmodule
`default_nettype wire

// [tb_led_serial_port.sv]
// Self-checking bench of the serial word port: frames, status readback, faults, interrupts.
// Assumes the controller model and the design files compile first.
`timescale 1ns/1ps
`default_nettype none
`include "led_port_cfg.svh"
module tb_led_serial_port;
  import led_port_pkg::*;
  localparam logic [2:0] REV = 3'h5; // Arbitrary revision value
  logic ref_clk_i, resetn_i, thermal_trip_i, reg_wr_i, reg_rd_i;
  logic sclk, sdi, load, sdo, irq_o;
  logic [7:0] open_a_i, open_b_i, reg_addr_i, led_a_o, led_b_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, rd;
  dac_type dac_a_o, dac_b_o;
  word_type st, w1, w2;
  int n_mismatch, cmp_count;
  led_serial_port #(.MASK_REV(REV), .WD_CYC(50)) dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .serial_bit_clock_i(sclk), .serial_data_in_i(sdi), .load_i(load), .thermal_trip_i(thermal_trip_i),
    .open_a_i(open_a_i), .open_b_i(open_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .serial_data_out_o(sdo),
    .led_a_o(led_a_o), .led_b_o(led_b_o), .dac_a_o(dac_a_o), .dac_b_o(dac_b_o), .irq_o(irq_o));
  ctrl_model ctrl (.ref_clk_i(ref_clk_i), .serial_data_out_i(sdo), .serial_bit_clock_o(sclk),
    .serial_data_in_o(sdi), .load_o(load));
  // 10 MHz core clock
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  // Compare and count
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Register write: one strobe cycle
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // Register read: data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // Data word from its fields, lowest numbered bit at the field LSB
  function automatic word_type mk(input logic [2:0] ad, input level_type ia, input level_type ib,
                                  input logic wd, input logic [3:0] dv, input dac_type da, input dac_type db);
    return {db, da, dv, wd, ib, ia, ad};
  endfunction
  // Expected status word; an open output reads zero
  function automatic word_type exp_st(input logic th, input logic wd);
    return {15'h2AAA, REV, th, wd, ~open_b_i, ~open_a_i};
  endfunction
  // Verdict and end of run
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    test_done();
  end
  // Main sequence
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    resetn_i = 1'b0;
    thermal_trip_i = 1'b0;
    open_a_i = 8'h05;
    open_b_i = 8'h80;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    w1 = mk(3'h5, 10'h3FF, 10'h000, 1'b1, 4'h2, 4'hA, 4'h3);
    w2 = mk(3'h2, 10'h155, 10'h2AA, 1'b0, 4'h2, 4'hA, 4'h3);
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    reg_read(`REG_CONFIG, rd);
    check("config after reset", rd, 0);
    check("leds after reset", {led_a_o, led_b_o, irq_o}, 0);
    ctrl.frame(w1, st);
    repeat (20) @(posedge ref_clk_i);
    check("dac a", dac_a_o, 4'hA);
    check("dac b", dac_b_o, 4'h3);
    reg_read(`REG_CONFIG, rd);
    check("config word 1", rd, 32'h000033A2);
    check("full scale led", led_a_o[5], 1'b1);
    check("zero level led", led_b_o[5], 1'b0);
    @(posedge ref_clk_i);
    thermal_trip_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    check("thermal kill", {led_a_o, led_b_o}, 0);
    ctrl.frame(w2, st);
    check("status out 1", st, exp_st(1'b0, 1'b0));
    reg_read(`REG_CONFIG, rd);
    check("config word 2", rd, 32'h000023A2);
    repeat (80) @(posedge ref_clk_i);
    reg_read(`REG_STATUS, rd);
    check("status reg timeout", rd, exp_st(1'b1, 1'b1) & 36'h0001FFFFF);
    reg_read(`REG_IRQ_STAT, rd);
    check("wdog event", rd[1], 1'b1);
    ctrl.frame(w1, st);
    check("status out 2", st, exp_st(1'b1, 1'b0));
    reg_read(`REG_STATUS, rd);
    check("status reg cleared", rd, exp_st(1'b1, 1'b0) & 36'h0001FFFFF);
    @(posedge ref_clk_i);
    thermal_trip_i <= 1'b0;
    open_b_i <= 8'h00;
    reg_write(`REG_IRQ_MASK, 32'h0);
    repeat (3) @(posedge ref_clk_i);
    check("irq masked", irq_o, 1'b0);
    reg_write(`REG_IRQ_MASK, 32'h1);
    repeat (3) @(posedge ref_clk_i);
    check("irq raised", irq_o, 1'b1);
    reg_read(`REG_IRQ_MASK, rd);
    check("mask readback", rd, 32'h1);
    reg_write(`REG_IRQ_STAT, 32'hF);
    repeat (3) @(posedge ref_clk_i);
    check("irq cleared", irq_o, 1'b0);
    reg_read(8'h20, rd);
    check("unmapped read", rd, 0);
    reg_read(`REG_STATUS, rd);
    check("bank b closed", rd[15:8], 8'hFF);
    test_done();
  end
endmodule
`default_nettype wire
